// ### hdl/iab_pkg.sv
// Contract
// - Own target address sits in bits 7:1; answer only on matching calling address.
// - Multiplier field bits 7:6: code 00 gives 1, 01 gives 2, 10 gives 4.
// - Index bits 5:0 pick a divider and hold count from a fixed table.
// - Bit rate equals bus clock over multiplier times divider.
// - Data changes hold count bus cycles after each serial clock fall.
// - Indices 00 to 1F give printed pairs, 20/7 up to 240/33.
// - Indices 20 to 3F give printed pairs, 160/17 up to 3840/513.
package iab_pkg;

    // register field layout
    localparam int ADDR_MSB     = 7;
    localparam int ADDR_LSB     = 1;
    localparam int RATE_MULTIPLIER_MSB     = 7;
    localparam int RATE_MULTIPLIER_LSB     = 6;
    localparam int IDX_MSB      = 5;
    localparam int IDX_LSB      = 0;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h00;

    // multiplier encodings
    localparam logic [1:0] RATE_MULTIPLIER_X1  = 2'h0;
    localparam logic [1:0] RATE_MULTIPLIER_X2  = 2'h1;
    localparam logic [1:0] RATE_MULTIPLIER_X4  = 2'h2;

    // widths of derived counts
    localparam int DIV_W    = 12;
    localparam int HOLD_W   = 10;
    localparam int PERIOD_W = 14;

    // serial clock dividers per index
    localparam logic [11:0] SCL_DIV [0:63] = '{
        12'd20,   12'd22,   12'd24,   12'd26,   12'd28,   12'd30,   12'd34,   12'd40,
        12'd28,   12'd32,   12'd36,   12'd40,   12'd44,   12'd48,   12'd56,   12'd68,
        12'd48,   12'd56,   12'd64,   12'd72,   12'd80,   12'd88,   12'd104,  12'd128,
        12'd80,   12'd96,   12'd112,  12'd128,  12'd144,  12'd160,  12'd192,  12'd240,
        12'd160,  12'd192,  12'd224,  12'd256,  12'd288,  12'd320,  12'd384,  12'd480,
        12'd320,  12'd384,  12'd448,  12'd512,  12'd576,  12'd640,  12'd768,  12'd960,
        12'd640,  12'd768,  12'd896,  12'd1024, 12'd1152, 12'd1280, 12'd1536, 12'd1920,
        12'd1280, 12'd1536, 12'd1792, 12'd2048, 12'd2304, 12'd2560, 12'd3072, 12'd3840
    };

    // data hold counts per index
    localparam logic [9:0] SDA_HOLD [0:63] = '{
        10'd7,   10'd7,   10'd8,   10'd8,   10'd9,   10'd9,   10'd10,  10'd10,
        10'd7,   10'd7,   10'd9,   10'd9,   10'd11,  10'd11,  10'd13,  10'd13,
        10'd9,   10'd9,   10'd13,  10'd13,  10'd17,  10'd17,  10'd21,  10'd21,
        10'd9,   10'd9,   10'd17,  10'd17,  10'd25,  10'd25,  10'd33,  10'd33,
        10'd17,  10'd17,  10'd33,  10'd33,  10'd49,  10'd49,  10'd65,  10'd65,
        10'd33,  10'd33,  10'd65,  10'd65,  10'd97,  10'd97,  10'd129, 10'd129,
        10'd65,  10'd65,  10'd129, 10'd129, 10'd193, 10'd193, 10'd257, 10'd257,
        10'd129, 10'd129, 10'd257, 10'd257, 10'd385, 10'd385, 10'd513, 10'd513
    };

    // shift amount for the multiplier; reserved code falls back to x1
    function automatic logic [1:0] rate_multiplier_shift(input logic [1:0] code);
        rate_multiplier_shift = (code == RATE_MULTIPLIER_X2) ? 2'h1 : (code == RATE_MULTIPLIER_X4) ? 2'h2 : 2'h0;
    endfunction

    // bit period in bus cycles = multiplier times divider
    function automatic logic [13:0] bit_period(input logic [1:0] code,
                                               input logic [11:0] div);
        bit_period = {2'h0, div} << rate_multiplier_shift(code);
    endfunction

endpackage

// ### hdl/iab_rate_if.sv
`timescale 1ns/1ps
// carries the registered rate setting to the table and the derived counts back
interface iab_rate_if;
    logic [1:0]  rateMult;
    logic [5:0]  rateIdx;
    logic [11:0] sclDivider;
    logic [9:0]  holdValue;
    logic [13:0] bitPeriod;

    modport table_side (input rateMult, input rateIdx,
                        output sclDivider, output holdValue, output bitPeriod);
    modport user_side  (output rateMult, output rateIdx,
                        input sclDivider, input holdValue, input bitPeriod);
endinterface

// ### hdl/iab_rate_table.sv
`timescale 1ns/1ps
// purely combinational lookup, so the counter sees a change at its next reload
module iab_rate_table (
    iab_rate_if.table_side rate
);
    // divider and hold straight from the fixed table
    always_comb begin
        rate.sclDivider = iab_pkg::SCL_DIV[rate.rateIdx];
        rate.holdValue  = iab_pkg::SDA_HOLD[rate.rateIdx];
        rate.bitPeriod  = iab_pkg::bit_period(rate.rateMult, rate.sclDivider);
    end
endmodule

// ### hdl/iab_addr_rate.sv
`timescale 1ns/1ps
module iab_addr_rate (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        addrWe,
    input  wire logic [7:0]  addrWrData,
    input  wire logic        rateWe,
    input  wire logic [7:0]  rateWrData,
    input  wire logic        sclRun,
    input  wire logic        callValid,
    input  wire logic [6:0]  callAddr,
    output logic      [7:0]  ownTargetAddress,
    output logic      [7:0]  bitRateDivider,
    output logic             addrMatch,
    output logic             sclLow,
    output logic             sclFall,
    output logic             sdaChange,
    output logic      [13:0] bitPeriodOut,
    output logic      [9:0]  holdOut
);
    logic [7:0]  ownAddr_q;
    logic [7:0]  rateDiv_q;
    logic        match_q;
    logic        active_q;
    logic [13:0] cnt_q;
    logic [13:0] period_q;
    logic [9:0]  hold_q;
    logic [9:0]  holdCnt_q;
    logic        sclLow_q;
    logic        sclFall_q;
    logic        sdaChange_q;
    logic        startBit;
    logic [13:0] nextCnt;

    iab_rate_if rate ();

    assign rate.rateMult = rateDiv_q[iab_pkg::RATE_MULTIPLIER_MSB:iab_pkg::RATE_MULTIPLIER_LSB];
    assign rate.rateIdx  = rateDiv_q[iab_pkg::IDX_MSB:iab_pkg::IDX_LSB];

    iab_rate_table u_table (
        .rate (rate)
    );

    // register writes; a reserved multiplier code is stored but treated as x1
    always_ff @(posedge clk) begin
        if (reset) begin
            ownAddr_q <= iab_pkg::ADDR_RESET;
            rateDiv_q <= iab_pkg::RATE_RESET;
        end else if (ce) begin
            if (addrWe) begin
                ownAddr_q <= addrWrData;
            end
            if (rateWe) begin
                rateDiv_q <= rateWrData;
            end
        end
    end

    // compare a presented calling address against the stored own address
    always_ff @(posedge clk) begin
        if (reset) begin
            match_q <= 1'b0;
        end else if (ce) begin
            match_q <= callValid &&
                (callAddr == ownAddr_q[iab_pkg::ADDR_MSB:iab_pkg::ADDR_LSB]);
        end
    end

    // a bit starts when the generator is enabled or the last cycle of a period ends
    assign startBit = sclRun && (!active_q || (cnt_q == period_q - 14'h0001));
    assign nextCnt  = cnt_q + 14'h0001;

    // bit period counter; period and hold reload only at a bit start
    always_ff @(posedge clk) begin
        if (reset) begin
            active_q <= 1'b0;
            cnt_q    <= 14'h0000;
            period_q <= 14'h0000;
            hold_q   <= 10'h000;
        end else if (ce) begin
            if (startBit) begin
                active_q <= 1'b1;
                cnt_q    <= 14'h0000;
                period_q <= rate.bitPeriod;
                hold_q   <= rate.holdValue;
            end else if (sclRun) begin
                cnt_q <= nextCnt;
            end else begin
                active_q <= 1'b0;
                cnt_q    <= 14'h0000;
            end
        end
    end

    // low for the first half of the period, released high for the rest
    always_ff @(posedge clk) begin
        if (reset) begin
            sclLow_q  <= 1'b0;
            sclFall_q <= 1'b0;
        end else if (ce) begin
            sclLow_q  <= sclRun && (startBit || (nextCnt < {1'b0, period_q[13:1]}));
            sclFall_q <= startBit;
        end
    end

    // data change strobe a hold count after each fall; hold is always below half a period
    always_ff @(posedge clk) begin
        if (reset) begin
            holdCnt_q   <= 10'h000;
            sdaChange_q <= 1'b0;
        end else if (ce) begin
            if (startBit) begin
                holdCnt_q <= rate.holdValue;
            end else if (holdCnt_q != 10'h000) begin
                holdCnt_q <= holdCnt_q - 10'h001;
            end
            sdaChange_q <= !startBit && (holdCnt_q == 10'h001);
        end
    end

    // outputs straight from flip-flops
    assign ownTargetAddress = ownAddr_q;
    assign bitRateDivider   = rateDiv_q;
    assign addrMatch        = match_q;
    assign sclLow           = sclLow_q;
    assign sclFall          = sclFall_q;
    assign sdaChange        = sdaChange_q;
    assign bitPeriodOut     = period_q;
    assign holdOut          = hold_q;

    // helper: cycles since the last serial clock fall, saturating
    logic [13:0] sinceFall_q;
    logic        seenFall_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            sinceFall_q <= 14'h0000;
            seenFall_q  <= 1'b0;
        end else if (ce) begin
            if (sclFall_q) begin
                sinceFall_q <= 14'h0001;
                seenFall_q  <= 1'b1;
            end else if (sinceFall_q != 14'h3FFF) begin
                sinceFall_q <= sinceFall_q + 14'h0001;
            end
            if (!sclRun) begin
                seenFall_q <= 1'b0;
            end
        end
    end

    sequence s_bitStart;
        ce && startBit;
    endsequence

    sequence s_fallSeen;
        sclFall_q && sclLow_q;
    endsequence

    a_addr_store : assert property (@(posedge clk) disable iff (reset)
        ce && addrWe |=> ownAddr_q == $past(addrWrData))
        else $error("own address not stored");

    a_match_hit : assert property (@(posedge clk) disable iff (reset)
        ce && !addrWe && callValid && callAddr == ownAddr_q[7:1] |=> addrMatch)
        else $error("matching address not flagged");

    a_match_miss : assert property (@(posedge clk) disable iff (reset)
        ce && (!callValid || callAddr != ownAddr_q[7:1]) |=> !addrMatch)
        else $error("address flagged without match");

    a_period_load : assert property (@(posedge clk) disable iff (reset)
        s_bitStart |=> period_q == ({2'h0, $past(rate.sclDivider)} <<
            (($past(rate.rateMult) == 2'h1) ? 1 : ($past(rate.rateMult) == 2'h2) ? 2 : 0)))
        else $error("bit period not multiplier times divider");

    a_table_ends : assert property (@(posedge clk) disable iff (reset)
        (rate.rateIdx == 6'h00 |-> rate.sclDivider == 12'd20 && rate.holdValue == 10'd7) and
        (rate.rateIdx == 6'h1F |-> rate.sclDivider == 12'd240 && rate.holdValue == 10'd33) and
        (rate.rateIdx == 6'h20 |-> rate.sclDivider == 12'd160 && rate.holdValue == 10'd17) and
        (rate.rateIdx == 6'h3F |-> rate.sclDivider == 12'd3840 && rate.holdValue == 10'd513))
        else $error("table end values wrong");

    // spot checks inside the table, at indices the bench exercises
    a_table_mid : assert property (@(posedge clk) disable iff (reset)
        (rate.rateIdx == 6'h01 |-> rate.sclDivider == 12'd22 && rate.holdValue == 10'd7) and
        (rate.rateIdx == 6'h07 |-> rate.sclDivider == 12'd40 && rate.holdValue == 10'd10) and
        (rate.rateIdx == 6'h0B |-> rate.sclDivider == 12'd40 && rate.holdValue == 10'd9))
        else $error("table inner values wrong");

    // dropping the run level must release the serial clock on the very next cycle
    a_low_stop : assert property (@(posedge clk) disable iff (reset)
        ce && !sclRun |=> !sclLow_q)
        else $error("serial clock held low after stop");

    a_fall_pulse : assert property (@(posedge clk) disable iff (reset)
        ce && sclFall_q |=> !sclFall_q)
        else $error("fall strobe longer than one cycle");

    a_sda_pulse : assert property (@(posedge clk) disable iff (reset)
        ce && sdaChange_q |=> !sdaChange_q)
        else $error("data change strobe longer than one cycle");

    a_hold_reload : assert property (@(posedge clk) disable iff (reset)
        s_bitStart |=> hold_q == $past(rate.holdValue))
        else $error("hold count not latched at bit start");

    a_fall_start : assert property (@(posedge clk) disable iff (reset)
        s_bitStart |=> s_fallSeen)
        else $error("bit start without serial clock fall");

    a_period_span : assert property (@(posedge clk) disable iff (reset)
        ce && sclFall_q && seenFall_q && sclRun |-> sinceFall_q == $past(period_q))
        else $error("bit period span wrong");

    a_hold_delay : assert property (@(posedge clk) disable iff (reset)
        sdaChange_q |-> sinceFall_q == {4'h0, hold_q})
        else $error("data change not at hold count");

    a_high_phase : assert property (@(posedge clk) disable iff (reset)
        ce && sclRun && active_q && !startBit && nextCnt >= {1'b0, period_q[13:1]}
        |=> !sclLow_q)
        else $error("serial clock low in high phase");
endmodule

// ### tb/iab_bus_caller.sv
`timescale 1ns/1ps
// another bus device presenting a calling address for one bus cycle
module iab_bus_caller (
    input  wire logic       clk,
    input  wire logic       sendReq,
    input  wire logic [6:0] sendAddr,
    output logic            callValid,
    output logic      [6:0] callAddr
);
    initial callValid = 1'b0;
    initial callAddr = 7'h00;
    // once released the address lines toggle, so a stale match cannot pass
    always @(negedge clk) begin
        callValid <= sendReq;
        callAddr  <= sendReq ? sendAddr : ~callAddr;
    end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [7:0] code; logic [13:0] per; logic [9:0] hold;} iab_row_t;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    logic        addrWe = 1'b0;
    logic        rateWe = 1'b0;
    logic        sclRun = 1'b0;
    logic        sendReq = 1'b0;
    logic [7:0]  addrWrData = 8'h00;
    logic [7:0]  rateWrData = 8'h00;
    logic [6:0]  sendAddr = 7'h00;
    logic        callValid, addrMatch, sclLow, sclFall, sdaChange;
    logic [6:0]  callAddr;
    logic [7:0]  ownTargetAddress, bitRateDivider;
    logic [13:0] bitPeriodOut;
    logic [9:0]  holdOut;
    int          bad_count = 0;
    int          n_compared = 0;
    // every rate here stays at or below bus clock over 20, code 11 never used
    iab_row_t    rows [6] = '{'{8'h00, 14'h0014, 10'h007}, '{8'h4B, 14'h0050, 10'h009},
        '{8'h1F, 14'h00F0, 10'h021}, '{8'h20, 14'h00A0, 10'h011},
        '{8'h81, 14'h0058, 10'h007}, '{8'h3F, 14'h0F00, 10'h201}};

    always #2 clk = ~clk;

    iab_addr_rate DUT (.clk(clk), .reset(reset), .ce(ce), .addrWe(addrWe),
        .addrWrData(addrWrData), .rateWe(rateWe), .rateWrData(rateWrData), .sclRun(sclRun),
        .callValid(callValid), .callAddr(callAddr), .ownTargetAddress(ownTargetAddress),
        .bitRateDivider(bitRateDivider), .addrMatch(addrMatch), .sclLow(sclLow),
        .sclFall(sclFall), .sdaChange(sdaChange), .bitPeriodOut(bitPeriodOut),
        .holdOut(holdOut));
    iab_bus_caller PEER (.clk(clk), .sendReq(sendReq), .sendAddr(sendAddr),
        .callValid(callValid), .callAddr(callAddr));

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe, data held until the strobe drops
    task automatic wr_reg(input logic isRate, input logic [7:0] data);
        @(negedge clk);
        if (isRate) begin rateWrData = data; rateWe = 1'b1; end
        else begin addrWrData = data; addrWe = 1'b1; end
        @(negedge clk);
        rateWe = 1'b0;
        addrWe = 1'b0;
    endtask

    // calling address from the peer, match expected one cycle later for one cycle
    task automatic call(input logic [6:0] a, input logic exp);
        @(negedge clk);
        sendAddr <= a;
        sendReq  <= 1'b1;
        @(negedge clk);
        sendReq  <= 1'b0;
        @(negedge clk);
        chk(addrMatch, exp);
        @(negedge clk);
        chk(addrMatch, 1'b0);
    endtask

    // runs one bit; optionally rewrites the rate mid-bit and checks the next bit
    task automatic measure(input iab_row_t r, input logic upd, input logic [13:0] nPer);
        int n;
        int lowCnt;
        int sdaAt;
        n = 0;
        sdaAt = -1;
        sclRun = 1'b1;
        while (sclFall !== 1'b1 && n < 20) begin @(negedge clk); n++; end
        if (n == 20) begin bad_count++; end_of_test(); end
        chk(bitPeriodOut, r.per);
        chk(holdOut, r.hold);
        lowCnt = (sclLow === 1'b1);
        n = 0;
        rateWrData = 8'h07;
        do begin
            @(negedge clk);
            n++;
            rateWe = upd && (n == 3);
            if (sdaChange === 1'b1) sdaAt = n;
            if (sclFall !== 1'b1) lowCnt += (sclLow === 1'b1);
        end while (sclFall !== 1'b1 && n < 5000);
        if (n >= 5000) begin bad_count++; end_of_test(); end
        chk(n, r.per);
        chk(sdaAt, r.hold);
        chk(lowCnt, r.per / 2);
        if (upd) chk(bitPeriodOut, nPer);
        sclRun = 1'b0;
        repeat (2) @(negedge clk);
        chk(sclLow, 1'b0);
    endtask

    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        chk(ownTargetAddress, 8'h00);
        chk(bitRateDivider, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            wr_reg(1'b1, rows[i].code);
            chk(bitRateDivider, rows[i].code);
            measure(rows[i], 1'b0, 14'h0000);
        end
        $display("test rate table done");
        wr_reg(1'b1, 8'h00);
        measure(rows[0], 1'b1, 14'h0028);
        $display("test rate change done");
        wr_reg(1'b0, 8'h54);
        chk(ownTargetAddress, 8'h54);
        call(7'h2A, 1'b1);
        call(7'h2B, 1'b0);
        @(negedge clk);
        ce = 1'b0;
        wr_reg(1'b0, 8'h12);
        ce = 1'b1;
        chk(ownTargetAddress, 8'h54);
        $display("test address done");
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk(ownTargetAddress, 8'h00);
        call(7'h2A, 1'b0);
        $display("test second reset done");
        end_of_test();
    end
endmodule
